// file: hdl/izg_pkg.sv
// Purpose: Shared constants for the index pulse direction gate
// Assumes: 32-bit APB register bus, byte addresses
// Notes:   Offsets, reset values and cycle counts live here
package izg_pkg;

    // Register byte offsets
    localparam logic [7:0] IZG_CFG_OFS    = 8'h00;
    localparam logic [7:0] IZG_CTRL_OFS   = 8'h04;
    localparam logic [7:0] IZG_STATUS_OFS = 8'h08;
    localparam logic [7:0] IZG_POS_OFS    = 8'h0c;
    localparam logic [7:0] IZG_LATCH_OFS  = 8'h10;

    // Field positions
    localparam int IZG_CFG_SEL_BIT     = 0;
    localparam int IZG_CTRL_SERIAL_BIT = 0;
    localparam int IZG_CTRL_ROT_BIT    = 1;
    localparam int IZG_CTRL_EXT_BIT    = 2;
    localparam int IZG_CTRL_RST_BIT    = 3;
    localparam int IZG_ST_BIDIR_BIT    = 0;
    localparam int IZG_ST_SERIAL_BIT   = 1;
    localparam int IZG_ST_ARMED_LSB    = 8;

    // Reset values
    localparam logic [15:0] IZG_CFG_RST  = 16'h0000;
    localparam logic [2:0]  IZG_CTRL_RST = 3'h0;

    // Shift between the two direction settings, as a fraction of a pitch
    localparam int IZG_EIGHTH_DIV = 8;

    // Index pulse widths in pclk cycles
    localparam logic [3:0] IZG_PULSE_WIDE   = 4'h4;
    localparam logic [3:0] IZG_PULSE_NARROW = 4'h2;

    // Number of cycles after the first access cycle until pready
    localparam int IZG_APB_WAIT = 1;

endpackage

// file: hdl/izg_pulse_shaper.sv
// Purpose: Stretches a one-cycle index event into an output pulse
// Assumes: Fire is a single-cycle strobe
// Notes:   Narrow width is used for bidirectional emission
`timescale 1ns/100ps
module izg_pulse_shaper
    import izg_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic fire,
    input  wire logic narrow,
    output logic      pulse_out
);

    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic       pulse_ff;

    always_comb begin
        if (fire) begin
            nxt_cnt = narrow ? IZG_PULSE_NARROW : IZG_PULSE_WIDE;
        end else if (cnt_ff != 4'h0) begin
            nxt_cnt = cnt_ff - 4'h1;
        end else begin
            nxt_cnt = 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff   <= 4'h0;
            pulse_ff <= 1'b0;
        end else begin
            cnt_ff   <= nxt_cnt;
            pulse_ff <= (nxt_cnt != 4'h0);
        end
    end

    assign pulse_out = pulse_ff;

endmodule

// file: hdl/izg_zero_table.sv
// Purpose: Per zero point arming and position match
// Assumes: Step, step_pos and arm describe the same count edge
// Notes:   Table full means further zero points stay unarmed
`timescale 1ns/100ps
module izg_zero_table
    import izg_pkg::*;
#(
    parameter int NZ = 4,
    parameter int PW = 24
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          clear,
    input  wire logic          step,
    input  wire logic          step_fwd,
    input  wire logic [PW-1:0] step_pos,
    input  wire logic          bidir,
    input  wire logic          arm,
    input  wire logic [PW-1:0] arm_pos,
    output logic               hit,
    output logic [NZ-1:0]      armed,
    output logic [PW-1:0]      hit_pos
);

    localparam int IW = (NZ > 1) ? $clog2(NZ) : 1;

    logic [PW-1:0] slot_pos_ff [NZ];
    logic [NZ-1:0] armed_ff;
    logic          hit_ff;
    logic [PW-1:0] hit_pos_ff;
    logic [NZ-1:0] step_match;
    logic [NZ-1:0] arm_match;
    logic [IW-1:0] free_idx;
    logic          free_ok;
    logic          nxt_hit;

    function automatic logic [NZ-1:0] match_vec(input logic [PW-1:0] p);
        logic [NZ-1:0] m;
        m = '0;
        for (int i = 0; i < NZ; i++) begin
            m[i] = armed_ff[i] && (slot_pos_ff[i] == p);
        end
        return m;
    endfunction

    always_comb begin
        step_match = match_vec(step_pos);
        arm_match  = match_vec(arm_pos);
        free_idx   = '0;
        free_ok    = 1'b0;
        for (int i = NZ - 1; i >= 0; i--) begin
            if (!armed_ff[i]) begin
                free_idx = IW'(i);
                free_ok  = 1'b1;
            end
        end
    end

    // Stored pass, forward only, each zero point in its own slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_ff <= '0;
            for (int i = 0; i < NZ; i++) begin
                slot_pos_ff[i] <= '0;
            end
        end else if (clear) begin
            armed_ff <= '0;
        end else if (arm && (arm_match == '0) && free_ok) begin
            armed_ff[free_idx]    <= 1'b1;
            slot_pos_ff[free_idx] <= arm_pos;
        end
    end

    // Outside a clear cycle, armed slot fires forward always, in reverse only when bidir
    always_comb begin
        nxt_hit = step && !clear &&
                  (((step_match != '0) && (step_fwd || bidir)) ||
                   (arm && (arm_pos == step_pos)));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_ff     <= 1'b0;
            hit_pos_ff <= '0;
        end else begin
            hit_ff <= nxt_hit;
            if (nxt_hit) begin
                hit_pos_ff <= step_pos;
            end
        end
    end

    assign hit     = hit_ff;
    assign armed   = armed_ff;
    assign hit_pos = hit_pos_ff;

endmodule

// file: hdl/izg_gate.sv
// Purpose: Gates the divided index pulse for an external linear scale
// Assumes: Scale count and zero strobes are synchronous to pclk
// Notes:   Direction select takes effect at reset or soft restart, serial bit at once
`timescale 1ns/100ps
module izg_gate
    import izg_pkg::*;
#(
    parameter int NZ           = 4,
    parameter int PW           = 24,
    parameter int PITCH_COUNTS = 256
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scale_count_en,
    input  wire logic        scale_count_up,
    input  wire logic        scale_zero_strobe,
    output logic             divided_index_output
);

    localparam logic [PW-1:0] EIGHTH =
        PW'(PITCH_COUNTS / IZG_EIGHTH_DIV);
    localparam int APB_WAIT = IZG_APB_WAIT;

    logic [15:0]   index_direction_config_ff;
    logic          serial_ff;
    logic          rotation_sense_select_ff;
    logic          external_scale_usage_ff;
    logic          active_sel_ff;
    logic          restart_ff;
    logic          pready_ff;
    logic          pslverr_ff;
    logic [31:0]   prdata_ff;
    logic [31:0]   nxt_prdata;
    logic          nxt_pready;
    logic          nxt_active_sel;
    logic [PW-1:0] pos_ff;
    logic [PW-1:0] nxt_pos;
    logic [PW-1:0] arm_pos;
    logic          bidir;
    logic          arm;
    logic          wr_en;
    logic          idx_hit;
    logic [NZ-1:0] armed_mask;
    logic [PW-1:0] latch_pos;

    function automatic logic reg_mapped(input logic [7:0] a);
        return (a == IZG_CFG_OFS) || (a == IZG_CTRL_OFS) ||
               (a == IZG_STATUS_OFS) || (a == IZG_POS_OFS) ||
               (a == IZG_LATCH_OFS);
    endfunction

    // APB slave: one wait cycle, then a single-cycle pready
    assign nxt_pready = psel && penable && !pready_ff;
    assign wr_en      = psel && penable && pready_ff && pwrite &&
                        reg_mapped(paddr);

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            IZG_CFG_OFS: begin
                nxt_prdata = {16'h0000, index_direction_config_ff};
            end
            IZG_CTRL_OFS: begin
                nxt_prdata = {29'h0000_0000, external_scale_usage_ff,
                              rotation_sense_select_ff, serial_ff};
            end
            IZG_STATUS_OFS: begin
                nxt_prdata[IZG_ST_BIDIR_BIT]  = bidir;
                nxt_prdata[IZG_ST_SERIAL_BIT] = serial_ff;
                nxt_prdata[IZG_ST_ARMED_LSB +: NZ] = armed_mask;
            end
            IZG_POS_OFS: begin
                nxt_prdata[PW-1:0] = pos_ff;
            end
            IZG_LATCH_OFS: begin
                nxt_prdata[PW-1:0] = latch_pos;
            end
            default: begin
                nxt_prdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pready && !reg_mapped(paddr);
            if (nxt_pready && !pwrite) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_direction_config_ff <= IZG_CFG_RST;
        end else if (wr_en && (paddr == IZG_CFG_OFS)) begin
            index_direction_config_ff <= pwdata[15:0];
        end
    end

    // Rotation and usage bits are held for software only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {external_scale_usage_ff, rotation_sense_select_ff,
             serial_ff} <= IZG_CTRL_RST;
        end else if (wr_en && (paddr == IZG_CTRL_OFS)) begin
            serial_ff                <= pwdata[IZG_CTRL_SERIAL_BIT];
            rotation_sense_select_ff <= pwdata[IZG_CTRL_ROT_BIT];
            external_scale_usage_ff  <= pwdata[IZG_CTRL_EXT_BIT];
        end
    end

    // Soft restart strobe, one cycle after the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_ff <= 1'b0;
        end else begin
            restart_ff <= wr_en && (paddr == IZG_CTRL_OFS) &&
                          pwdata[IZG_CTRL_RST_BIT];
        end
    end

    // Direction select only latched at restart
    assign nxt_active_sel = restart_ff ?
        index_direction_config_ff[IZG_CFG_SEL_BIT] : active_sel_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_sel_ff <= IZG_CFG_RST[IZG_CFG_SEL_BIT];
        end else begin
            active_sel_ff <= nxt_active_sel;
        end
    end

    assign bidir = active_sel_ff || serial_ff;

    // Scale position follows the count direction only
    always_comb begin
        nxt_pos = pos_ff;
        if (scale_count_en) begin
            nxt_pos = scale_count_up ? pos_ff + PW'(1) : pos_ff - PW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_ff <= '0;
        end else begin
            pos_ff <= nxt_pos;
        end
    end

    // Zero strobe arms only on a forward count
    assign arm = scale_zero_strobe && scale_count_en &&
                 scale_count_up;
    assign arm_pos = nxt_pos + (bidir ? EIGHTH : PW'(0));

    izg_zero_table #(
        .NZ (NZ),
        .PW (PW)
    ) u_table (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (restart_ff),
        .step     (scale_count_en),
        .step_fwd (scale_count_up),
        .step_pos (nxt_pos),
        .bidir    (bidir),
        .arm      (arm),
        .arm_pos  (arm_pos),
        .hit      (idx_hit),
        .armed    (armed_mask),
        .hit_pos  (latch_pos)
    );

    izg_pulse_shaper u_shaper (
        .pclk      (pclk),
        .presetn   (presetn),
        .fire      (idx_hit),
        .narrow    (bidir),
        .pulse_out (divided_index_output)
    );

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_REV_UNARMED: assert property (
        scale_count_en && !scale_count_up && armed_mask == '0
        |=> !idx_hit)
        else $error("Reverse pass fired on an unarmed zero point");

    AST_FWD_FIRST: assert property (
        arm && !bidir && !restart_ff |=> idx_hit)
        else $error("First forward pass did not fire");

    AST_ARM_STORES: assert property (
        arm && !restart_ff && armed_mask == '0
        |=> armed_mask != '0)
        else $error("Forward pass position not stored");

    AST_FWD_ONLY: assert property (
        !bidir && scale_count_en && !scale_count_up |=> !idx_hit)
        else $error("Reverse emission in forward-only mode");

    AST_SERIAL_BIDIR: assert property (
        serial_ff && scale_count_en && !scale_count_up && !restart_ff &&
        u_table.step_match != '0 |=> idx_hit)
        else $error("Serial converter did not force both directions");

    AST_WIDE_PULSE: assert property (
        idx_hit && !bidir |=> divided_index_output [*4])
        else $error("Forward-only index pulse too short");

    AST_SHIFT: assert property (
        arm && bidir |-> arm_pos == nxt_pos + EIGHTH)
        else $error("Bidirectional index position not shifted");

    AST_RESTART_CLEAR: assert property (
        restart_ff |=> armed_mask == '0 ##1 active_sel_ff ==
        $past(index_direction_config_ff[IZG_CFG_SEL_BIT], 2))
        else $error("Restart did not clear arming or load select");

    AST_DIR_ONLY: assert property (
        idx_hit |-> $past(scale_count_en))
        else $error("Index pulse without a scale count");

    AST_KEEP: assert property (
        !restart_ff |=> (armed_mask & $past(armed_mask)) ==
        $past(armed_mask))
        else $error("Arming of another zero point was lost");

    // Outside a restart cycle, reverse pass over a stored slot fires whenever bidirectional
    AST_REV_MATCH: assert property (
        scale_count_en && !scale_count_up && bidir && !restart_ff &&
        u_table.step_match != '0 |=> idx_hit)
        else $error("Reverse pass over a stored position did not fire");

    AST_REV_NO_ARM: assert property (
        scale_count_en && !scale_count_up && !restart_ff
        |=> armed_mask == $past(armed_mask))
        else $error("Reverse pass armed a zero point");

    AST_SEL_HOLD: assert property (
        !restart_ff |=> $stable(active_sel_ff))
        else $error("Direction select changed without a restart");

    AST_CLEAR_NO_FIRE: assert property (
        restart_ff |=> !idx_hit)
        else $error("Index fired in the restart cycle");

    AST_SERIAL_NOW: assert property (
        psel && penable && pready && pwrite && paddr == IZG_CTRL_OFS &&
        pwdata[IZG_CTRL_SERIAL_BIT] |=> bidir)
        else $error("Serial attachment did not act at once");

    AST_BIDIR_SHIFTED: assert property (
        arm && bidir && !restart_ff && armed_mask == '0 |=> !idx_hit)
        else $error("Bidirectional pass fired at the unshifted position");

    // Position follows the count direction and nothing else
    AST_POS_STEP: assert property (
        scale_count_en |=> pos_ff == ($past(scale_count_up) ?
            $past(pos_ff) + PW'(1) : $past(pos_ff) - PW'(1)))
        else $error("Position did not follow the count direction");

    AST_POS_IDLE: assert property (
        !scale_count_en |=> $stable(pos_ff))
        else $error("Position moved without a count step");

    AST_LATCH_POS: assert property (
        idx_hit |-> latch_pos == $past(nxt_pos))
        else $error("Latched index position differs from the pass");

    // Pulse width bounds; narrow width is the floor in every mode
    AST_NARROW_MIN: assert property (
        idx_hit |=> divided_index_output ##1 divided_index_output)
        else $error("Index pulse shorter than the narrow width");

    AST_NARROW_END: assert property (
        idx_hit && bidir ##1 !idx_hit ##1 !idx_hit
        |=> !divided_index_output)
        else $error("Bidirectional index pulse too long");

    AST_WIDE_END: assert property (
        idx_hit && !bidir ##1 !idx_hit [*4]
        |=> !divided_index_output)
        else $error("Forward-only index pulse too long");

    // Bus: one wait cycle, single-cycle answer, read data held
    AST_APB_WAIT: assert property (
        psel && !penable ##1 psel && penable |-> ##APB_WAIT pready)
        else $error("Bus answer not after one wait cycle");

    AST_APB_PULSE: assert property (
        pready |=> !pready)
        else $error("Bus ready held longer than one cycle");

    AST_ERR_WITH_READY: assert property (
        pslverr |-> pready)
        else $error("Bus error flag without ready");

    AST_READ_HOLD: assert property (
        !(psel && penable && !pready && !pwrite) |=> $stable(prdata))
        else $error("Read data changed outside a read");

    COV_FWD_FIRE: cover property (arm ##1 idx_hit);
    COV_REV_FIRE: cover property (
        scale_count_en && !scale_count_up && bidir ##1 idx_hit);
    COV_RESTART: cover property (restart_ff && armed_mask != '0);
    COV_SERIAL_REV: cover property (
        serial_ff && scale_count_en && !scale_count_up ##1 idx_hit);

endmodule

// file: test/izg_scale_model.sv
// Purpose: Behavioural external linear scale, steps and zero strobes
// Assumes: One step is a one-cycle count_en pulse
// Notes:   Zero points at Z0 and Z1; idle direction line toggles
`timescale 1ns/100ps
module izg_scale_model #(
    parameter int Z0 = -20,
    parameter int Z1 = 20
) (
    input  wire logic pclk,
    output logic      count_en,
    output logic      count_up,
    output logic      zero_strobe
);
    int pos;

    initial begin
        count_en    = 1'b0;
        count_up    = 1'b0;
        zero_strobe = 1'b0;
        pos         = 0;
    end

    // Steps n counts; gap plus one idle cycles after each step set the speed
    task automatic move(input int n, input logic up, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            pos = up ? pos + 1 : pos - 1;
            count_en    <= 1'b1;
            count_up    <= up;
            zero_strobe <= (pos == Z0) || (pos == Z1);
            @(posedge pclk);
            count_en    <= 1'b0;
            count_up    <= ~up;
            zero_strobe <= 1'b0;
            repeat (gap) @(posedge pclk);
        end
    endtask
endmodule

// file: test/tb_index_pulse_direction_gate.sv
// Purpose: Self-checking bench for the index pulse direction gate
// Assumes: Default parameters, pitch of 256 counts
// Notes:   Pulses counted by rising edges and cycles high
`timescale 1ns/100ps
module tb_index_pulse_direction_gate
    import izg_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cnt_en;
    logic        cnt_up;
    logic        zstb;
    logic        idx;
    logic        idx_prev;
    logic [31:0] rd;
    logic        err;
    logic [31:0] l0;
    logic [23:0] dif;
    int          fail_count;
    int          checks;
    int          edges;
    int          hi;
    int          cyc;

    izg_gate u_izg_gate (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scale_count_en(cnt_en),
        .scale_count_up(cnt_up), .scale_zero_strobe(zstb),
        .divided_index_output(idx)
    );

    izg_scale_model u_izg_scale_model (
        .pclk(pclk), .count_en(cnt_en), .count_up(cnt_up),
        .zero_strobe(zstb)
    );

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        idx_prev <= idx;
        if (idx === 1'b1) hi++;
        if (idx === 1'b1 && idx_prev !== 1'b1) edges++;
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Moves the scale, then checks pulse count and total width
    task automatic run(input int n, input logic up, input int gap,
                       input int np, input int w);
        edges = 0;
        hi    = 0;
        u_izg_scale_model.move(n, up, gap);
        repeat (8) @(posedge pclk);
        chk("pulse count", np, edges);
        chk("pulse width", np * w, hi);
    endtask

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; idx_prev = 1'b0;
        fail_count = 0; checks = 0; edges = 0; hi = 0; cyc = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, IZG_CFG_OFS, 32'h0);
        chk("cfg reset", {16'h0, IZG_CFG_RST}, rd);
        xfer(1'b0, IZG_CTRL_OFS, 32'h0);
        chk("ctrl reset", {29'h0, IZG_CTRL_RST}, rd);
        xfer(1'b0, IZG_STATUS_OFS, 32'h0);
        chk("status reset", 32'h0, rd);
        xfer(1'b0, 8'h14, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        xfer(1'b1, IZG_CFG_OFS, 32'hffff_a5a4);
        xfer(1'b0, IZG_CFG_OFS, 32'h0);
        chk("cfg rw", 32'h0000_a5a4, rd);
        // Keep select 0, rotation and usage bits set
        xfer(1'b1, IZG_CFG_OFS, 32'h0);
        xfer(1'b1, IZG_CTRL_OFS, 32'h6);
        xfer(1'b0, IZG_CTRL_OFS, 32'h0);
        chk("ctrl rw", 32'h6, rd);
        run(30, 1'b0, 0, 0, 4);
        run(60, 1'b1, 6, 2, 4);
        xfer(1'b0, IZG_STATUS_OFS, 32'h0);
        chk("armed count", 32'h2, $countones(rd[11:8]));
        xfer(1'b0, IZG_LATCH_OFS, 32'h0);
        l0 = rd;
        run(30, 1'b0, 6, 0, 4);
        run(30, 1'b1, 6, 1, 4);
        // Both directions after restart
        xfer(1'b1, IZG_CFG_OFS, 32'h1);
        xfer(1'b1, IZG_CTRL_OFS, 32'h8);
        xfer(1'b0, IZG_STATUS_OFS, 32'h0);
        chk("bidir status", 32'h1, rd);
        run(30, 1'b0, 6, 0, 2);
        run(60, 1'b1, 6, 1, 2);
        xfer(1'b0, IZG_LATCH_OFS, 32'h0);
        dif = rd[23:0] - l0[23:0];
        chk("eighth", 32'(256 / IZG_EIGHTH_DIV), {8'h0, dif});
        run(60, 1'b0, 6, 1, 2);
        // Serial converter forces both directions
        xfer(1'b1, IZG_CFG_OFS, 32'h0);
        xfer(1'b1, IZG_CTRL_OFS, 32'h9);
        xfer(1'b0, IZG_STATUS_OFS, 32'h0);
        chk("serial status", 32'h1, {31'h0, rd[1]});
        run(60, 1'b1, 6, 1, 2);
        run(60, 1'b0, 6, 1, 2);
        test_done();
    end
endmodule
